/* rtl/soec_consts.svh */
`ifndef SOEC_CONSTS_SVH
`define SOEC_CONSTS_SVH

// Register indexes
`define SOEC_IDX_PLL_CTRL  8'h00
`define SOEC_IDX_OE_LOW    8'h01
`define SOEC_IDX_OE_HIGH   8'h02
`define SOEC_IDX_PIN_RB    8'h03
`define SOEC_IDX_COUNT     8'h07

// Writable bits and reset values
`define SOEC_PLL_RW_MASK   8'h18
`define SOEC_PLL_RESET     8'h18
`define SOEC_OE_LOW_MASK   8'hf7
`define SOEC_OE_LOW_RESET  8'hff
`define SOEC_OE_HIGH_MASK  8'hbd
`define SOEC_OE_HIGH_RESET 8'hfd
`define SOEC_COUNT_MASK    8'h1f
`define SOEC_COUNT_RESET   8'h08

// Serial framing
`define SOEC_BITS_PER_BYTE 4'h8
`define SOEC_FIRST_BIT     4'h1
`define SOEC_ADDR_BASE     7'h68

`endif

/* rtl/soec_pkg.sv */
package soec_pkg;

  typedef enum logic [2:0] {
    LK_IDLE,
    LK_RX,
    LK_ACK,
    LK_TX,
    LK_MACK
  } soec_link_state_t;

  typedef enum logic [1:0] {
    BK_ADDR,
    BK_CMD,
    BK_CNT,
    BK_DATA
  } soec_byte_kind_t;

endpackage

/* rtl/soec_sync.sv */
`timescale 1ns/1ps
module soec_sync #(
  parameter int W = 1
) (
  // Destination clock
  input  wire  logic         clk,
  input  wire  logic         rst,
  // Level in and out
  input  wire  logic [W-1:0] d,
  output logic       [W-1:0] q
);

  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
    end
  end

  assign q = s2_reg;

endmodule // soec_sync

/* rtl/soec_xfer.sv */
`timescale 1ns/1ps
module soec_xfer #(
  parameter int W = 8
) (
  // Source domain
  input  wire  logic         src_clk,
  input  wire  logic         src_rst,
  input  wire  logic         src_go,
  input  wire  logic [W-1:0] src_data,
  output logic               src_busy,
  // Destination domain
  input  wire  logic         dst_clk,
  input  wire  logic         dst_rst,
  output logic               dst_valid,
  output logic       [W-1:0] dst_data
);

  logic         tog_reg;
  logic [W-1:0] hold_reg;
  logic         ack_s;
  logic         tog_s;
  logic         seen_reg;
  logic         valid_reg;
  logic [W-1:0] data_reg;

  soec_sync #(.W(1)) u_fwd (
    .clk (dst_clk),
    .rst (dst_rst),
    .d   (tog_reg),
    .q   (tog_s)
  );

  soec_sync #(.W(1)) u_back (
    .clk (src_clk),
    .rst (src_rst),
    .d   (seen_reg),
    .q   (ack_s)
  );

  // A word held here stays put until the far side has echoed the toggle
  assign src_busy = tog_reg != ack_s;

  always_ff @(posedge src_clk) begin
    if (src_rst) begin
      tog_reg  <= 1'b0;
      hold_reg <= '0;
    end else if (src_go && !src_busy) begin
      tog_reg  <= ~tog_reg;
      hold_reg <= src_data;
    end
  end

  always_ff @(posedge dst_clk) begin
    if (dst_rst) begin
      seen_reg  <= 1'b0;
      valid_reg <= 1'b0;
      data_reg  <= '0;
    end else begin
      seen_reg  <= tog_s;
      valid_reg <= tog_s != seen_reg;
      if (tog_s != seen_reg) begin
        data_reg <= hold_reg;
      end
    end
  end

  assign dst_valid = valid_reg;
  assign dst_data  = data_reg;

endmodule // soec_xfer

/* rtl/soec_ctrl.sv */
`timescale 1ns/1ps
`include "soec_consts.svh"
module soec_ctrl import soec_pkg::*; #(
  parameter logic [6:0] ADDR_BASE = `SOEC_ADDR_BASE
) (
  // System clock and reset
  input  wire  logic        sys_clk,
  input  wire  logic        srst,
  // Power and strap pins
  input  wire  logic        pwr_good,
  input  wire  logic [1:0]  pll_mode_strap,
  input  wire  logic        freq_select_strap,
  input  wire  logic [3:0]  addr_sel,
  // Gate pins for outputs 12,11,10,8,7,6,5 (bit 6 down to 0)
  input  wire  logic [6:0]  gate_pin_n,
  // Serial link
  input  wire  logic        link_clk,
  input  wire  logic        smb_scl_in,
  input  wire  logic        smb_sda_in,
  output logic              smb_sda_out,
  output logic              smb_sda_oe_n,
  // Output pair enables
  output logic [17:0]       diff_clock_output_en
);

  ////////////////////////////////////////////////////////////////////////////
  // Decoders

  function automatic logic [17:0] build_en(
    input logic [7:0] pll_b,
    input logic [7:0] lo_b,
    input logic [7:0] hi_b,
    input logic [6:0] pin_n
  );
    logic [17:0] e;
    e = '0;
    e[0]  = lo_b[0];
    e[1]  = lo_b[1];
    e[2]  = lo_b[2];
    e[4]  = lo_b[4];
    e[5]  = lo_b[5] & ~pin_n[0];
    e[6]  = lo_b[6] & ~pin_n[1];
    e[7]  = lo_b[7] & ~pin_n[2];
    e[8]  = hi_b[0] & ~pin_n[3];
    e[10] = hi_b[2] & ~pin_n[4];
    e[11] = hi_b[3] & ~pin_n[5];
    e[12] = hi_b[4] & ~pin_n[6];
    e[13] = hi_b[5];
    e[15] = hi_b[7];
    e[16] = pll_b[3];
    e[17] = pll_b[4];
    return e;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // System domain: pins and register bank

  logic [1:0]  mode_s;
  logic        freq_s;
  logic        pg_s;
  logic [6:0]  gate_s;
  logic        pg_prev_reg;
  logic [1:0]  pll_mode_latched_reg;
  logic        freq_select_latched_reg;
  logic [7:0]  pll_ctrl_reg;
  logic [7:0]  oe_low_reg;
  logic [7:0]  oe_high_reg;
  logic [7:0]  readback_count_field_reg;
  logic [17:0] en_reg;
  logic        wr_valid;
  logic [15:0] wr_word;
  logic        rq_valid;
  logic [8:0]  rq_word;
  logic        rsp_go_reg;
  logic [7:0]  rsp_data_reg;
  logic [7:0]  gate_pin_level_readback;
  logic        pg_rise;

  soec_sync #(.W(11)) u_pin_sync (
    .clk (sys_clk),
    .rst (srst),
    .d   ({pwr_good, pll_mode_strap, freq_select_strap, gate_pin_n}),
    .q   ({pg_s, mode_s, freq_s, gate_s})
  );

  assign pg_rise = pg_s & ~pg_prev_reg;

  // Capture on the power-good edge only, so later strap moves are not seen
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pg_prev_reg             <= 1'b0;
      pll_mode_latched_reg    <= 2'h0;
      freq_select_latched_reg <= 1'b0;
    end else begin
      pg_prev_reg <= pg_s;
      if (pg_rise) begin
        pll_mode_latched_reg    <= mode_s;
        freq_select_latched_reg <= freq_s;
      end
    end
  end

  // Live pin levels, reserved bit 4 low
  assign gate_pin_level_readback = {gate_s[6:4], 1'b0, gate_s[3:0]};

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pll_ctrl_reg             <= `SOEC_PLL_RESET;
      oe_low_reg               <= `SOEC_OE_LOW_RESET;
      oe_high_reg              <= `SOEC_OE_HIGH_RESET;
      readback_count_field_reg <= `SOEC_COUNT_RESET;
    end else if (wr_valid) begin
      // Read-only and reserved bits keep their value through the masks
      unique case (wr_word[15:8])
        `SOEC_IDX_PLL_CTRL:
          pll_ctrl_reg <= (pll_ctrl_reg & ~`SOEC_PLL_RW_MASK)
                        | (wr_word[7:0] & `SOEC_PLL_RW_MASK);
        `SOEC_IDX_OE_LOW:
          oe_low_reg <= (oe_low_reg & ~`SOEC_OE_LOW_MASK)
                      | (wr_word[7:0] & `SOEC_OE_LOW_MASK);
        `SOEC_IDX_OE_HIGH:
          oe_high_reg <= (oe_high_reg & ~`SOEC_OE_HIGH_MASK)
                       | (wr_word[7:0] & `SOEC_OE_HIGH_MASK);
        `SOEC_IDX_COUNT:
          readback_count_field_reg <= wr_word[7:0] & `SOEC_COUNT_MASK;
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      en_reg <= '0;
    end else begin
      en_reg <= build_en(pll_ctrl_reg, oe_low_reg, oe_high_reg,
                         gate_s);
    end
  end

  assign diff_clock_output_en = en_reg;

  // Read answers; bit 8 of a request asks for the byte count instead
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rsp_go_reg   <= 1'b0;
      rsp_data_reg <= 8'h00;
    end else begin
      rsp_go_reg <= rq_valid;
      if (rq_valid) begin
        if (rq_word[8]) begin
          rsp_data_reg <= readback_count_field_reg;
        end else begin
          unique case (rq_word[7:0])
            `SOEC_IDX_PLL_CTRL:
              rsp_data_reg <= {pll_mode_latched_reg,
                               pll_ctrl_reg[5:1],
                               freq_select_latched_reg};
            `SOEC_IDX_OE_LOW:  rsp_data_reg <= oe_low_reg;
            `SOEC_IDX_OE_HIGH: rsp_data_reg <= oe_high_reg;
            `SOEC_IDX_PIN_RB:  rsp_data_reg <= gate_pin_level_readback;
            `SOEC_IDX_COUNT:   rsp_data_reg <= readback_count_field_reg;
            default:           rsp_data_reg <= 8'h00;
          endcase
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: serial engine

  logic              link_rst;
  logic              scl_s;
  logic              sda_s;
  logic [3:0]        sel_s;
  logic              scl_prev_reg;
  logic              sda_prev_reg;
  soec_link_state_t  state_reg;
  soec_byte_kind_t   kind_reg;
  logic [3:0]        bitcnt_reg;
  logic [7:0]        rx_sh_reg;
  logic [7:0]        tx_sh_reg;
  logic              rw_reg;
  logic [7:0]        idx_reg;
  logic [7:0]        wcnt_reg;
  logic              sda_low_reg;
  logic              wr_go_reg;
  logic [15:0]       wr_data_reg;
  logic              rq_go_reg;
  logic [8:0]        rq_data_reg;
  logic [7:0]        rsp_link;
  logic              scl_rise;
  logic              scl_fall;
  logic              start_cond;
  logic              stop_cond;
  logic [6:0]        slave_addr;
  logic              addr_match;

  soec_sync #(.W(1)) u_rst_sync (
    .clk (link_clk),
    .rst (1'b0),
    .d   (srst),
    .q   (link_rst)
  );

  // Not reset, so the edge detectors wake up at the idle bus level
  soec_sync #(.W(6)) u_bus_sync (
    .clk (link_clk),
    .rst (1'b0),
    .d   ({smb_scl_in, smb_sda_in, addr_sel}),
    .q   ({scl_s, sda_s, sel_s})
  );

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= scl_s;
      sda_prev_reg <= sda_s;
    end
  end

  assign scl_rise   = scl_s & ~scl_prev_reg;
  assign scl_fall   = ~scl_s & scl_prev_reg;
  assign start_cond = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
  assign stop_cond  = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;
  assign slave_addr = ADDR_BASE + {3'h0, sel_s};
  assign addr_match = rx_sh_reg[7:1] == slave_addr;

  // The index survives a repeated start so a read resumes where set.
  // Read answers must return within one clock-high time; the crossing
  // takes well under a microsecond, far inside any legal bus timing.
  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      state_reg   <= LK_IDLE;
      kind_reg    <= BK_ADDR;
      bitcnt_reg  <= 4'h0;
      rx_sh_reg   <= 8'h00;
      tx_sh_reg   <= 8'h00;
      rw_reg      <= 1'b0;
      idx_reg     <= 8'h00;
      wcnt_reg    <= 8'h00;
      sda_low_reg <= 1'b0;
      wr_go_reg   <= 1'b0;
      wr_data_reg <= 16'h0000;
      rq_go_reg   <= 1'b0;
      rq_data_reg <= 9'h000;
    end else begin
      wr_go_reg <= 1'b0;
      rq_go_reg <= 1'b0;
      if (start_cond) begin
        state_reg   <= LK_RX;
        kind_reg    <= BK_ADDR;
        bitcnt_reg  <= 4'h0;
        sda_low_reg <= 1'b0;
      end else if (stop_cond) begin
        state_reg   <= LK_IDLE;
        sda_low_reg <= 1'b0;
      end else begin
        unique case (state_reg)
          LK_IDLE: ;
          LK_RX: begin
            if (scl_rise && bitcnt_reg != `SOEC_BITS_PER_BYTE) begin
              rx_sh_reg  <= {rx_sh_reg[6:0], sda_s};
              bitcnt_reg <= bitcnt_reg + `SOEC_FIRST_BIT;
            end else if (scl_fall && bitcnt_reg == `SOEC_BITS_PER_BYTE) begin
              bitcnt_reg <= 4'h0;
              if (kind_reg == BK_ADDR && !addr_match) begin
                state_reg <= LK_IDLE;
              end else begin
                state_reg   <= LK_ACK;
                sda_low_reg <= 1'b1;
                unique case (kind_reg)
                  BK_ADDR: begin
                    rw_reg <= rx_sh_reg[0];
                    if (rx_sh_reg[0]) begin
                      rq_go_reg   <= 1'b1;
                      rq_data_reg <= {1'b1, idx_reg};
                    end
                  end
                  BK_CMD: idx_reg  <= rx_sh_reg;
                  BK_CNT: wcnt_reg <= rx_sh_reg;
                  BK_DATA: begin
                    if (wcnt_reg != 8'h00) begin
                      wr_go_reg   <= 1'b1;
                      wr_data_reg <= {idx_reg, rx_sh_reg};
                      idx_reg     <= idx_reg + 8'h01;
                      wcnt_reg    <= wcnt_reg - 8'h01;
                    end
                  end
                endcase
              end
            end
          end
          LK_ACK: begin
            if (scl_fall) begin
              if (kind_reg == BK_ADDR && rw_reg) begin
                state_reg   <= LK_TX;
                tx_sh_reg   <= rsp_link;
                sda_low_reg <= ~rsp_link[7];
                bitcnt_reg  <= `SOEC_FIRST_BIT;
              end else begin
                state_reg   <= LK_RX;
                sda_low_reg <= 1'b0;
                unique case (kind_reg)
                  BK_ADDR: kind_reg <= BK_CMD;
                  BK_CMD:  kind_reg <= BK_CNT;
                  BK_CNT:  kind_reg <= BK_DATA;
                  BK_DATA: kind_reg <= BK_DATA;
                endcase
              end
            end
          end
          LK_TX: begin
            if (scl_fall) begin
              if (bitcnt_reg == `SOEC_BITS_PER_BYTE) begin
                state_reg   <= LK_MACK;
                sda_low_reg <= 1'b0;
              end else begin
                tx_sh_reg   <= {tx_sh_reg[6:0], 1'b0};
                sda_low_reg <= ~tx_sh_reg[6];
                bitcnt_reg  <= bitcnt_reg + `SOEC_FIRST_BIT;
              end
            end
          end
          LK_MACK: begin
            if (scl_rise) begin
              if (!sda_s) begin
                rq_go_reg   <= 1'b1;
                rq_data_reg <= {1'b0, idx_reg};
                idx_reg     <= idx_reg + 8'h01;
              end else begin
                state_reg <= LK_IDLE;
              end
            end else if (scl_fall) begin
              state_reg   <= LK_TX;
              tx_sh_reg   <= rsp_link;
              sda_low_reg <= ~rsp_link[7];
              bitcnt_reg  <= `SOEC_FIRST_BIT;
            end
          end
        endcase
      end
    end
  end

  // Open drain: only ever pulls low
  assign smb_sda_out  = 1'b0;
  assign smb_sda_oe_n = ~sda_low_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Crossings

  soec_xfer #(.W(16)) u_wr_xfer (
    .src_clk   (link_clk),
    .src_rst   (link_rst),
    .src_go    (wr_go_reg),
    .src_data  (wr_data_reg),
    .src_busy  (),
    .dst_clk   (sys_clk),
    .dst_rst   (srst),
    .dst_valid (wr_valid),
    .dst_data  (wr_word)
  );

  soec_xfer #(.W(9)) u_rq_xfer (
    .src_clk   (link_clk),
    .src_rst   (link_rst),
    .src_go    (rq_go_reg),
    .src_data  (rq_data_reg),
    .src_busy  (),
    .dst_clk   (sys_clk),
    .dst_rst   (srst),
    .dst_valid (rq_valid),
    .dst_data  (rq_word)
  );

  soec_xfer #(.W(8)) u_rsp_xfer (
    .src_clk   (sys_clk),
    .src_rst   (srst),
    .src_go    (rsp_go_reg),
    .src_data  (rsp_data_reg),
    .src_busy  (),
    .dst_clk   (link_clk),
    .dst_rst   (link_rst),
    .dst_valid (),
    .dst_data  (rsp_link)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_addr_done;
    state_reg == LK_RX && kind_reg == BK_ADDR && scl_fall &&
    bitcnt_reg == `SOEC_BITS_PER_BYTE && !start_cond && !stop_cond;
  endsequence

  sequence s_host_ack;
    state_reg == LK_MACK && scl_rise && !sda_s && !start_cond && !stop_cond;
  endsequence

  chk_addr_ack: assert property (
    @(posedge link_clk) disable iff (link_rst)
    s_addr_done and addr_match |=> state_reg == LK_ACK && !smb_sda_oe_n)
    else $error("own address not acknowledged");

  chk_addr_ignore: assert property (
    @(posedge link_clk) disable iff (link_rst)
    s_addr_done and !addr_match |=> state_reg == LK_IDLE && smb_sda_oe_n)
    else $error("foreign address acknowledged");

  chk_count_first: assert property (
    @(posedge link_clk) disable iff (link_rst)
    s_addr_done and (addr_match && rx_sh_reg[0])
    |=> rq_go_reg && rq_data_reg[8])
    else $error("byte count not fetched first");

  chk_data_ack: assert property (
    @(posedge link_clk) disable iff (link_rst)
    state_reg == LK_ACK && kind_reg == BK_DATA && !scl_fall &&
    !start_cond && !stop_cond |=> !smb_sda_oe_n)
    else $error("data byte ack dropped");

  chk_read_step: assert property (
    @(posedge link_clk) disable iff (link_rst)
    s_host_ack |=> rq_go_reg && !rq_data_reg[8] &&
                   idx_reg == rq_data_reg[7:0] + 8'h01)
    else $error("read index not stepped");

  chk_write_step: assert property (
    @(posedge link_clk) disable iff (link_rst)
    wr_go_reg |-> idx_reg == wr_data_reg[15:8] + 8'h01)
    else $error("write index not stepped");

  chk_reset_defaults: assert property (
    @(posedge sys_clk) disable iff (srst)
    $fell(srst) |-> oe_low_reg == `SOEC_OE_LOW_RESET &&
      oe_high_reg == `SOEC_OE_HIGH_RESET &&
      readback_count_field_reg == `SOEC_COUNT_RESET ##1
      diff_clock_output_en[0] && diff_clock_output_en[17])
    else $error("enable or count default wrong");

  chk_bit_override: assert property (
    @(posedge sys_clk) disable iff (srst)
    1'b1 |=> diff_clock_output_en[15] == $past(oe_high_reg[7]) &&
             diff_clock_output_en[12] ==
               $past(oe_high_reg[4] && !gate_s[6]))
    else $error("output enable does not follow its bit");

  chk_strap_hold: assert property (
    @(posedge sys_clk) disable iff (srst)
    !pg_rise |=> $stable(pll_mode_latched_reg) &&
                 $stable(freq_select_latched_reg))
    else $error("strap latch moved without power-good edge");

  chk_pin_live: assert property (
    @(posedge sys_clk) disable iff (srst)
    rq_valid && !rq_word[8] && rq_word[7:0] == `SOEC_IDX_PIN_RB
    |=> rsp_data_reg[7] == $past(gate_s[6]) && !rsp_data_reg[4])
    else $error("pin readback not live");

endmodule // soec_ctrl

/* tb/soec_host.sv */
`timescale 1ns/1ps
module soec_host (
  // Bus wires
  output logic       scl,
  output logic       sda_drv,
  input  wire  logic sda
);
  // 500 ns halves leave slack for the read fetch across domains
  localparam int HALF = 500;

  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  // Data moves mid-low so it never races the SCL fall
  task automatic bit_xfer(input logic b, output logic r);
    #(HALF / 2);
    sda_drv = b;
    #(HALF / 2);
    scl = 1'b1;
    #HALF;
    r = sda;
    scl = 1'b0;
  endtask

  // Serves as repeated start too: SDA raised while SCL is low
  task automatic start_cond();
    #(HALF / 2);
    sda_drv = 1'b1;
    #(HALF / 2);
    scl = 1'b1;
    #HALF;
    sda_drv = 1'b0;
    #HALF;
    scl = 1'b0;
  endtask

  task automatic stop_cond();
    #(HALF / 2);
    sda_drv = 1'b0;
    #(HALF / 2);
    scl = 1'b1;
    #HALF;
    sda_drv = 1'b1;
    #HALF;
  endtask

  task automatic wr_byte(input logic [7:0] d, output logic ack_n);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(d[i], r);
    end
    bit_xfer(1'b1, ack_n);
  endtask

  task automatic rd_byte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, r);
      d[i] = r;
    end
    bit_xfer(nack, r);
  endtask
endmodule // soec_host

/* tb/smbus_output_enable_control_tb.sv */
`timescale 1ns/1ps
`include "soec_consts.svh"
module smbus_output_enable_control_tb;
  localparam logic [6:0] BASE  = 7'h68;
  localparam int         LIMIT = 90000;
  logic        sys_clk = 1'b0;
  logic        link_clk = 1'b0;
  logic        srst = 1'b1;
  logic        pwr_good = 1'b0;
  logic [1:0]  pll_mode_strap = 2'h0;
  logic        freq_select_strap = 1'b0;
  logic [3:0]  addr_sel = 4'h0;
  logic [6:0]  gate_pin_n = 7'h00;
  logic        scl;
  logic        sda_drv;
  logic        smb_sda_out;
  logic        smb_sda_oe_n;
  logic [17:0] diff_clock_output_en;
  wire  logic  sda = sda_drv & (smb_sda_oe_n | smb_sda_out);
  logic [7:0]  mdl [0:255];
  logic [1:0]  mode_l;
  logic        freq_l;
  logic [6:0]  dev;
  int          error_cnt = 0;
  int          cmp_count = 0;
  int          cyc = 0;

  always #5 sys_clk = ~sys_clk;
  // Edges every 7.5 ns; every other one lands on a whole ns and can meet a system clock edge
  always #7.5 link_clk = ~link_clk;

  soec_ctrl #(.ADDR_BASE(BASE)) soec_ctrl_i (
    .sys_clk(sys_clk), .srst(srst), .pwr_good(pwr_good),
    .pll_mode_strap(pll_mode_strap), .freq_select_strap(freq_select_strap),
    .addr_sel(addr_sel), .gate_pin_n(gate_pin_n), .link_clk(link_clk),
    .smb_scl_in(scl), .smb_sda_in(sda), .smb_sda_out(smb_sda_out),
    .smb_sda_oe_n(smb_sda_oe_n), .diff_clock_output_en(diff_clock_output_en)
  );
  soec_host soec_host_i (.scl(scl), .sda_drv(sda_drv), .sda(sda));

  ////////////////////////////////////////////////////////////////////////
  task automatic fail(input logic [17:0] got, input logic [17:0] exp);
    error_cnt++;
    $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
  endtask
  task automatic cmp_ack(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) fail(18'(got), 18'(exp));
  endtask
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) fail(18'(got), 18'(exp));
  endtask
  task automatic cmp_en(input logic [17:0] got, input logic [17:0] exp);
    cmp_count++;
    if (got !== exp) fail(got, exp);
  endtask

  function automatic logic [7:0] wmask(input logic [7:0] i);
    case (i)
      8'h00: return `SOEC_PLL_RW_MASK;
      8'h01: return `SOEC_OE_LOW_MASK;
      8'h02: return `SOEC_OE_HIGH_MASK;
      8'h07: return `SOEC_COUNT_MASK;
      default: return 8'h00;
    endcase
  endfunction
  function automatic logic [7:0] rd_exp(input logic [7:0] i);
    case (i)
      8'h00: return {mode_l, 1'b0, mdl[0][4:3], 2'h0, freq_l};
      8'h01: return mdl[1] | 8'h08;
      8'h02: return mdl[2] | 8'h40;
      8'h03: return {gate_pin_n[6:4], 1'b0, gate_pin_n[3:0]};
      8'h07: return mdl[7];
      default: return 8'h00;
    endcase
  endfunction
  function automatic logic [17:0] exp_en();
    logic [7:0]  a;
    logic [7:0]  b;
    logic [17:0] e;
    int          o [7] = '{5, 6, 7, 8, 10, 11, 12};
    a = mdl[1];
    b = mdl[2];
    e = {mdl[0][4:3], b[7], 1'b0, b[5:2], 1'b0, b[0], a[7:4], 1'b0, a[2:0]};
    for (int i = 0; i < 7; i++) e[o[i]] = e[o[i]] & ~gate_pin_n[i];
    return e;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  task automatic addr_phase(input logic [7:0] n);
    logic a;
    host_start();
    soec_host_i.wr_byte({dev, 1'b0}, a);
    cmp_ack(a, 1'b0);
    soec_host_i.wr_byte(n, a);
    cmp_ack(a, 1'b0);
  endtask
  task automatic host_start();
    soec_host_i.start_cond();
  endtask
  task automatic blk_write(input logic [7:0] n, input logic [7:0] x,
                           input logic [7:0] d[$]);
    logic a;
    addr_phase(n);
    soec_host_i.wr_byte(x, a);
    cmp_ack(a, 1'b0);
    foreach (d[i]) begin
      soec_host_i.wr_byte(d[i], a);
      cmp_ack(a, 1'b0);
      if (i < x) mdl[8'(n + i)] = d[i] & wmask(8'(n + i));
    end
    soec_host_i.stop_cond();
  endtask
  task automatic blk_read(input logic [7:0] n, input int k);
    logic       a;
    logic [7:0] b;
    addr_phase(n);
    host_start();
    soec_host_i.wr_byte({dev, 1'b1}, a);
    cmp_ack(a, 1'b0);
    soec_host_i.rd_byte(1'b0, b);
    cmp_byte(b, mdl[7]);
    for (int i = 0; i < k; i++) begin
      soec_host_i.rd_byte(i == k - 1, b);
      cmp_byte(b, rd_exp(8'(n + i)));
    end
    soec_host_i.stop_cond();
  endtask
  task automatic chk_en();
    repeat (20) @(negedge sys_clk);
    cmp_en(diff_clock_output_en, exp_en());
  endtask

  task automatic close_out();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      error_cnt++;
      close_out();
    end
  end

  initial begin
    logic [7:0] q [$];
    logic [7:0] n;
    logic [7:0] x;
    logic       a;
    void'($urandom(32'hdfdf));
    mdl[0] = 8'h18;
    mdl[1] = 8'hf7;
    mdl[2] = 8'hbd;
    mdl[7] = 8'h08;
    @(negedge sys_clk);
    pll_mode_strap = 2'($urandom);
    freq_select_strap = 1'($urandom);
    addr_sel = 4'($urandom);
    dev = BASE + 7'(addr_sel);
    // Link side needs three of its own edges inside reset
    repeat (10) @(negedge sys_clk);
    srst = 1'b0;
    repeat (10) @(negedge sys_clk);
    pwr_good = 1'b1;
    mode_l = pll_mode_strap;
    freq_l = freq_select_strap;
    repeat (20) @(negedge sys_clk);
    pll_mode_strap = ~pll_mode_strap;
    freq_select_strap = ~freq_select_strap;
    chk_en();
    blk_read(8'h00, 9);
    for (int it = 0; it < 3; it++) begin
      gate_pin_n = 7'($urandom);
      q = {};
      n = 8'($urandom_range(2));
      x = 8'($urandom_range(3, 1));
      // One byte past the count must be acked but dropped
      repeat (x + 1) q.push_back(8'($urandom));
      blk_write(n, x, q);
      chk_en();
      blk_read(n, 3);
    end
    q = {8'($urandom)};
    blk_write(8'h07, 8'h01, q);
    blk_read(8'h07, 1);
    host_start();
    soec_host_i.wr_byte({dev + 7'h01, 1'b0}, a);
    cmp_ack(a, 1'b1);
    soec_host_i.stop_cond();
    close_out();
  end
endmodule // smbus_output_enable_control_tb
